// File: pkg/alb_pkg.sv
// Constants and types shared by the arithmetic, logic and branch execute block
//
// Notes on behaviour
// - Add: accumulator plus source into accumulator, update carry, sign, zero, overflow.
// - Add-with-carry: accumulator plus carry plus source into accumulator.
// - Eight-bit sources may take their upper operand byte from the prefix register.
// - Logical AND: source ANDed into accumulator, only sign and zero change.
// - Carry becomes carry AND selected accumulator bit; no other flag changes.
// - Call with 8-bit immediate is relative, signed reach +127 to -128 words.
// - Call with 16-bit immediate is absolute, high byte from prefix register.
// - Call pre-increments stack pointer and stores next instruction address there.
// - Call through an internal register is always absolute, register gives all 16 bits.
// - Compare sets equal flag on match, clears otherwise, accumulator untouched.
// - Complement: accumulator becomes its ones' complement, sign and zero updated.
// - Carry complement inverts carry and leaves other flags alone.
// - Decrement chosen loop counter; branch if nonzero, else step; no flags.
// - Jump: 8-bit immediate relative, 16-bit immediate absolute with prefix high byte.
// - Jump through an internal register always loads an absolute 16-bit address.
// - Conditional jumps on C, NC, Z, NZ, E, NE, S use jump target rules.
// - A false jump condition advances the program counter by one word.
// - Source with top bit zero is an 8-bit literal from the low byte.
`default_nettype none
package alb_pkg;
    localparam int          DATA_W        = 16;
    localparam int          NUM_ACC       = 16;
    localparam int          STACK_DEPTH   = 16;
    // Reset values
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    localparam logic [7:0]  PFX_RESET     = 8'h00;
    // Field positions in the instruction word
    localparam int          FMT_BIT       = 15;
    localparam int          OP_HI         = 14;
    localparam int          OP_LO         = 8;
    localparam int          BIT_SEL_HI    = 7;
    localparam int          BIT_SEL_LO    = 4;
    localparam int          LC_SEL_BIT    = 12;
    // Operation field codes, bits 14..8
    localparam logic [6:0]  OPF_ADD       = 7'h4A;
    localparam logic [6:0]  OPF_ADD_WITH_CARRY_OP      = 7'h6A;
    localparam logic [6:0]  OPF_AND       = 7'h1A;
    localparam logic [6:0]  OPF_CMP       = 7'h78;
    localparam logic [6:0]  OPF_CALL      = 7'h3D;
    localparam logic [6:0]  OPF_JUMP      = 7'h0C;
    localparam logic [6:0]  OPF_JC        = 7'h2C;
    localparam logic [6:0]  OPF_JNC       = 7'h6C;
    localparam logic [6:0]  OPF_JZ        = 7'h1C;
    localparam logic [6:0]  OPF_JNZ       = 7'h5C;
    localparam logic [6:0]  OPF_JE        = 7'h3C;
    localparam logic [6:0]  OPF_JNE       = 7'h7C;
    localparam logic [6:0]  OPF_JS        = 7'h4C;
    localparam logic [1:0]  OPF_DECREMENT_BRANCH_NONZERO_HI   = 2'b10;
    localparam logic [3:0]  OPF_DECREMENT_BRANCH_NONZERO_LO   = 4'hD;
    // Whole-word, high-byte and low-nibble codes
    localparam logic [15:0] INSTR_INVERT  = 16'h8A1A;
    localparam logic [15:0] INSTR_CPL_C   = 16'hDA2A;
    localparam logic [7:0]  HI_AND_BIT    = 8'h9A;
    localparam logic [3:0]  LO_AND_BIT    = 4'hA;
    // Source specifier codes {f, ssss ssss}
    localparam logic [3:0]  SRC_ACC_LO    = 4'h9;
    localparam logic [8:0]  SRC_PC        = 9'h10C;
    localparam logic [8:0]  SRC_SP        = 9'h11D;
    localparam logic [7:0]  SRC_LC_MASK   = 8'hEF;
    localparam logic [7:0]  SRC_LC_CODE   = 8'h6D;

    typedef enum logic [3:0] {
        ALB_NONE, ALB_ADD, ALB_ADD_WITH_CARRY_OP, ALB_AND, ALB_AND_BIT, ALB_INVERT,
        ALB_CPL_C, ALB_CMP, ALB_CALL, ALB_DECREMENT_BRANCH_NONZERO, ALB_JUMP
    } alb_op_e;
endpackage
`default_nettype wire

// File: rtl/alb_add16.sv
// Adder with carry in, carry out and signed overflow
`timescale 1ns/1ps
`default_nettype none
module alb_add16 #(
    parameter int WIDTH = 16
) (
    // Operands
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    input  wire logic             cin,
    // Result
    output logic      [WIDTH-1:0] sum,
    output logic                  cout,
    output logic                  ovf
);
    logic [WIDTH:0] full;

    assign full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
    assign sum  = full[WIDTH-1:0];
    assign cout = full[WIDTH];
    // Same-signed operands giving a result of the other sign
    assign ovf  = (a[WIDTH-1] == b[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]);
endmodule
`default_nettype wire

// File: rtl/alb_src_mux.sv
// Source operand selection and high byte formation
`timescale 1ns/1ps
`default_nettype none
module alb_src_mux #(
    parameter int NUM_ACC = 16,
    parameter int SP_W    = 4
) (
    // Specifier
    input  wire logic [8:0]            src_code,
    // Internal sources
    input  wire logic [NUM_ACC*16-1:0] acc_flat,
    input  wire logic [15:0]           lc0,
    input  wire logic [15:0]           lc1,
    input  wire logic [SP_W-1:0]       sp,
    input  wire logic [15:0]           pc,
    input  wire logic [7:0]            pfx,
    input  wire logic                  pfx_armed,
    // Outside registers
    input  wire logic [15:0]           ext_data,
    input  wire logic                  ext_is_word,
    // Result
    output logic      [15:0]           operand,
    output logic                       is_imm
);
    import alb_pkg::*;

    logic [15:0] raw;
    logic        wide;
    logic [7:0]  hi_byte;

    assign hi_byte = pfx_armed ? pfx : 8'h00;
    assign is_imm  = ~src_code[8];

    always_comb begin
        raw  = ext_data;
        wide = ext_is_word;
        if (!src_code[8]) begin
            raw  = {8'h00, src_code[7:0]};
            wide = 1'b0;
        end else if (src_code[3:0] == SRC_ACC_LO) begin
            raw  = acc_flat[src_code[7:4]*16 +: 16];
            wide = 1'b1;
        end else if ((src_code[7:0] & SRC_LC_MASK) == SRC_LC_CODE) begin
            raw  = src_code[4] ? lc1 : lc0;
            wide = 1'b1;
        end else if (src_code == SRC_SP) begin
            raw  = {{(16-SP_W){1'b0}}, sp};
            wide = 1'b1;
        end else if (src_code == SRC_PC) begin
            raw  = pc;
            wide = 1'b1;
        end
        operand = wide ? raw : {hi_byte, raw[7:0]};
    end
endmodule
`default_nettype wire

// File: rtl/alb_exec.sv
// Single-cycle execute unit for add, logic, compare, call, loop and jump instructions
`timescale 1ns/1ps
`default_nettype none
module alb_exec #(
    parameter int NUM_ACC     = alb_pkg::NUM_ACC,
    parameter int STACK_DEPTH = alb_pkg::STACK_DEPTH
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Program memory
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_valid,
    output logic      [15:0] program_counter,
    // Outside register source
    output logic      [8:0]  ext_src_sel,
    input  wire logic [15:0] ext_src_data,
    input  wire logic        ext_src_is_word,
    // Register loads from the move path
    input  wire logic [3:0]  acc_ptr,
    input  wire logic        acc_wr_en,
    input  wire logic [3:0]  acc_wr_idx,
    input  wire logic [15:0] acc_wr_data,
    input  wire logic        pfx_wr_en,
    input  wire logic [7:0]  pfx_wr_data,
    input  wire logic        lc_wr_en,
    input  wire logic        lc_wr_idx,
    input  wire logic [15:0] lc_wr_data,
    // Status
    output logic      [15:0] active_acc,
    output logic             carry_flag,
    output logic             sign_flag,
    output logic             zero_flag,
    output logic             equal_flag,
    output logic             twos_complement_wrap_flag,
    output logic      [$clog2(STACK_DEPTH)-1:0] stack_top_pointer,
    output logic      [15:0] stack_top_data,
    output logic      [15:0] loop_count_0,
    output logic      [15:0] loop_count_1,
    output logic      [7:0]  high_byte_prefix,
    output logic             instr_unsupported
);
    import alb_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]                   pc;
        logic [NUM_ACC-1:0][15:0]      acc;
        logic [7:0]                    pfx;
        logic                          pfx_armed;
        logic [1:0][15:0]              lc;
        logic [SP_W-1:0]               sp;
        logic [STACK_DEPTH-1:0][15:0]  stack;
        logic                          c;
        logic                          s;
        logic                          z;
        logic                          e;
        logic                          ov;
        logic                          unsup;
    } alb_state_s;

    alb_state_s state_reg;
    alb_state_s state_next;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [6:0]  opf;
    logic [8:0]  src_code;
    alb_op_e     op;
    logic        cond_true;

    assign opf      = instr_word[OP_HI:OP_LO];
    assign src_code = {instr_word[FMT_BIT], instr_word[7:0]};

    always_comb begin
        op        = ALB_NONE;
        cond_true = 1'b1;
        if (instr_word == INSTR_INVERT) begin
            op = ALB_INVERT;
        end else if (instr_word == INSTR_CPL_C) begin
            op = ALB_CPL_C;
        end else if (instr_word[15:8] == HI_AND_BIT && instr_word[3:0] == LO_AND_BIT) begin
            op = ALB_AND_BIT;
        end else if (opf[6:5] == OPF_DECREMENT_BRANCH_NONZERO_HI && opf[3:0] == OPF_DECREMENT_BRANCH_NONZERO_LO) begin
            op = ALB_DECREMENT_BRANCH_NONZERO;
        end else begin
            case (opf)
                OPF_ADD: begin
                    op = ALB_ADD;
                end
                OPF_ADD_WITH_CARRY_OP: begin
                    op = ALB_ADD_WITH_CARRY_OP;
                end
                OPF_AND: begin
                    op = ALB_AND;
                end
                OPF_CMP: begin
                    op = ALB_CMP;
                end
                OPF_CALL: begin
                    op = ALB_CALL;
                end
                OPF_JUMP: begin
                    op = ALB_JUMP;
                end
                OPF_JC: begin
                    op        = ALB_JUMP;
                    cond_true = state_reg.c;
                end
                OPF_JNC: begin
                    op        = ALB_JUMP;
                    cond_true = ~state_reg.c;
                end
                OPF_JZ: begin
                    op        = ALB_JUMP;
                    cond_true = state_reg.z;
                end
                OPF_JNZ: begin
                    op        = ALB_JUMP;
                    cond_true = ~state_reg.z;
                end
                OPF_JE: begin
                    op        = ALB_JUMP;
                    cond_true = state_reg.e;
                end
                OPF_JNE: begin
                    op        = ALB_JUMP;
                    cond_true = ~state_reg.e;
                end
                OPF_JS: begin
                    op        = ALB_JUMP;
                    cond_true = state_reg.s;
                end
                default: begin
                    op = ALB_NONE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Operand and arithmetic
    // ------------------------------------------------------------
    logic [15:0] operand;
    logic        src_is_imm;
    logic [15:0] cur_acc;
    logic [15:0] add_sum;
    logic        add_cout;
    logic        add_ovf;
    logic [15:0] pc_inc;
    logic [15:0] rel_target;
    logic [15:0] target;
    logic [15:0] lc_dec;

    assign ext_src_sel = src_code;
    assign cur_acc     = state_reg.acc[acc_ptr];
    assign pc_inc      = state_reg.pc + 16'h0001;
    assign lc_dec      = state_reg.lc[instr_word[LC_SEL_BIT]] - 16'h0001;

    alb_src_mux #(
        .NUM_ACC     (NUM_ACC),
        .SP_W        (SP_W)
    ) u_src (
        .src_code    (src_code),
        .acc_flat    (state_reg.acc),
        .lc0         (state_reg.lc[0]),
        .lc1         (state_reg.lc[1]),
        .sp          (state_reg.sp),
        .pc          (state_reg.pc),
        .pfx         (state_reg.pfx),
        .pfx_armed   (state_reg.pfx_armed),
        .ext_data    (ext_src_data),
        .ext_is_word (ext_src_is_word),
        .operand     (operand),
        .is_imm      (src_is_imm)
    );

    // Accumulator adder; carry in only for the carry form
    alb_add16 #(
        .WIDTH (DATA_W)
    ) u_alu_add (
        .a     (cur_acc),
        .b     (operand),
        .cin   ((op == ALB_ADD_WITH_CARRY_OP) ? state_reg.c : 1'b0),
        .sum   (add_sum),
        .cout  (add_cout),
        .ovf   (add_ovf)
    );

    // Branch offset adder, signed low byte
    alb_add16 #(
        .WIDTH (DATA_W)
    ) u_rel_add (
        .a     (state_reg.pc),
        .b     ({{8{src_code[7]}}, src_code[7:0]}),
        .cin   (1'b0),
        .sum   (rel_target),
        .cout  (),
        .ovf   ()
    );

    // Bare 8-bit immediate is relative; prefixed immediate or register is absolute
    assign target = (src_is_imm && !state_reg.pfx_armed) ? rel_target
                                                          : operand;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] res;
        res        = 16'h0000;
        state_next = state_reg;
        state_next.unsup = 1'b0;
        if (acc_wr_en) begin
            state_next.acc[acc_wr_idx] = acc_wr_data;
        end
        if (lc_wr_en) begin
            state_next.lc[lc_wr_idx] = lc_wr_data;
        end
        if (instr_valid) begin
            // Prefix applies to one instruction only
            state_next.pfx_armed = 1'b0;
            state_next.pc        = pc_inc;
            case (op)
                ALB_ADD, ALB_ADD_WITH_CARRY_OP: begin
                    state_next.acc[acc_ptr] = add_sum;
                    state_next.c            = add_cout;
                    state_next.ov           = add_ovf;
                    state_next.s            = add_sum[15];
                    state_next.z            = (add_sum == 16'h0000);
                end
                ALB_AND: begin
                    res                     = cur_acc & operand;
                    state_next.acc[acc_ptr] = res;
                    state_next.s            = res[15];
                    state_next.z            = (res == 16'h0000);
                end
                ALB_AND_BIT: begin
                    state_next.c = state_reg.c & cur_acc[instr_word[BIT_SEL_HI:BIT_SEL_LO]];
                end
                ALB_INVERT: begin
                    res                     = ~cur_acc;
                    state_next.acc[acc_ptr] = res;
                    state_next.s            = res[15];
                    state_next.z            = (res == 16'h0000);
                end
                ALB_CPL_C: begin
                    state_next.c = ~state_reg.c;
                end
                ALB_CMP: begin
                    state_next.e = (cur_acc == operand);
                end
                ALB_CALL: begin
                    state_next.sp                   = state_reg.sp + 1'b1;
                    state_next.stack[state_next.sp] = pc_inc;
                    state_next.pc                   = target;
                end
                ALB_DECREMENT_BRANCH_NONZERO: begin
                    state_next.lc[instr_word[LC_SEL_BIT]] = lc_dec;
                    if (lc_dec != 16'h0000) begin
                        state_next.pc = target;
                    end
                end
                ALB_JUMP: begin
                    if (cond_true) begin
                        state_next.pc = target;
                    end else begin
                        state_next.pc = pc_inc;
                    end
                end
                default: begin
                    state_next.unsup = 1'b1;
                end
            endcase
        end
        // A prefix load arriving with an instruction arms the next one
        if (pfx_wr_en) begin
            state_next.pfx       = pfx_wr_data;
            state_next.pfx_armed = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg           <= '0;
            state_reg.pc        <= PC_RESET;
            state_reg.pfx       <= PFX_RESET;
            state_reg.lc[0]     <= WORD_RESET;
            state_reg.lc[1]     <= WORD_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign program_counter           = state_reg.pc;
    assign active_acc                = cur_acc;
    assign carry_flag                = state_reg.c;
    assign sign_flag                 = state_reg.s;
    assign zero_flag                 = state_reg.z;
    assign equal_flag                = state_reg.e;
    assign twos_complement_wrap_flag = state_reg.ov;
    assign stack_top_pointer         = state_reg.sp;
    assign stack_top_data            = state_reg.stack[state_reg.sp];
    assign loop_count_0              = state_reg.lc[0];
    assign loop_count_1              = state_reg.lc[1];
    assign high_byte_prefix          = state_reg.pfx;
    assign instr_unsupported         = state_reg.unsup;
endmodule
`default_nettype wire

// File: tb/alb_exec_asserts.sv
// Port-level assertions for the execute unit
`timescale 1ns/1ps
`default_nettype none
module alb_exec_asserts
    import alb_pkg::*;
#(
    parameter int STACK_DEPTH = alb_pkg::STACK_DEPTH,
    parameter int SP_W        = $clog2(STACK_DEPTH)
) (
    // Clock, reset and instruction
    input wire logic            ref_clk,
    input wire logic            rst,
    input wire logic [15:0]     instr_word,
    input wire logic            instr_valid,
    input wire logic [15:0]     program_counter,
    // Loads
    input wire logic            acc_wr_en,
    input wire logic            pfx_wr_en,
    input wire logic            lc_wr_en,
    // Status
    input wire logic [15:0]     active_acc,
    input wire logic            carry_flag,
    input wire logic            sign_flag,
    input wire logic            zero_flag,
    input wire logic [SP_W-1:0] stack_top_pointer,
    input wire logic [15:0]     stack_top_data,
    input wire logic [15:0]     loop_count_1
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic           armed_reg;
    logic           bit_reg;
    wire logic [6:0] opf = instr_word[OP_HI:OP_LO];
    wire logic       go  = instr_valid && !acc_wr_en && !pfx_wr_en && !lc_wr_en;
    // Prefix arming and selected accumulator bit
    always_ff @(posedge ref_clk) begin
        if (rst) armed_reg <= 1'b0;
        else if (pfx_wr_en) armed_reg <= 1'b1;
        else if (instr_valid) armed_reg <= 1'b0;
        bit_reg <= active_acc[instr_word[7:4]];
    end
    carry_invert_a: assert property (
        go && instr_word == INSTR_CPL_C |=> carry_flag == !$past(carry_flag) && $stable({sign_flag, zero_flag}))
        else $error("carry complement wrong");
    acc_invert_a: assert property (
        go && instr_word == INSTR_INVERT |=> active_acc == ~$past(active_acc) && sign_flag == active_acc[15]
            && zero_flag == (active_acc == 16'h0000))
        else $error("accumulator complement wrong");
    carry_and_bit_a: assert property (
        go && instr_word[15:8] == HI_AND_BIT && instr_word[3:0] == LO_AND_BIT
            |=> carry_flag == ($past(carry_flag) && bit_reg) && $stable({sign_flag, zero_flag}))
        else $error("carry and bit wrong");
    compare_keep_a: assert property (
        go && opf == OPF_CMP |=> $stable(active_acc) && $stable({carry_flag, sign_flag, zero_flag}))
        else $error("compare changed state");
    call_push_a: assert property (
        go && opf == OPF_CALL |=> stack_top_pointer == $past(stack_top_pointer) + 1'b1
            && stack_top_data == $past(program_counter) + 16'h0001)
        else $error("call push wrong");
    loop_decrement_a: assert property (
        go && opf[6:5] == OPF_DECREMENT_BRANCH_NONZERO_HI && opf[3:0] == OPF_DECREMENT_BRANCH_NONZERO_LO && instr_word[LC_SEL_BIT]
            |=> loop_count_1 == $past(loop_count_1) - 16'h0001
            && (loop_count_1 != 16'h0000 || program_counter == $past(program_counter) + 16'h0001))
        else $error("loop decrement wrong");
    cond_not_taken_a: assert property (
        go && (opf == OPF_JC && !carry_flag || opf == OPF_JNC && carry_flag || opf == OPF_JZ && !zero_flag
            || opf == OPF_JNZ && zero_flag || opf == OPF_JS && !sign_flag)
            |=> program_counter == $past(program_counter) + 16'h0001)
        else $error("untaken jump did not step");
    rel_jump_a: assert property (
        go && !armed_reg && instr_word[15:8] == {1'b0, OPF_JUMP}
            |=> program_counter == $past(program_counter) + 16'($signed($past(instr_word[7:0]))))
        else $error("relative jump wrong");
endmodule
`default_nettype wire

// File: tb/alb_prog_mem.sv
// Program memory model feeding instruction words
`timescale 1ns/1ps
`default_nettype none
module alb_prog_mem (
    // Clock and loader
    input  wire logic        ref_clk,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    // Fetch
    input  wire logic [15:0] fetch_addr,
    output logic      [15:0] fetch_word
);
    logic [15:0] mem [256];
    // Loader writes the word at the current fetch address
    always @(posedge ref_clk) if (wr_en) mem[fetch_addr[7:0]] <= wr_data;
    assign fetch_word = mem[fetch_addr[7:0]];
endmodule
`default_nettype wire

// File: tb/tb_arith_logic_branch_exec.sv
// Self-checking bench for the execute unit
`timescale 1ns/1ps
`default_nettype none
module tb_arith_logic_branch_exec;
    import alb_pkg::*;
    localparam logic [6:0] JOPS [7] = '{OPF_JC, OPF_JNC, OPF_JZ, OPF_JNZ, OPF_JE, OPF_JNE, OPF_JS};
    logic        ref_clk, rst, instr_valid, mw_en, acc_wr_en, pfx_wr_en, lc_wr_en, lc_wr_idx, c_m;
    logic        carry_flag, sign_flag, zero_flag, equal_flag, ov_flag, unsup;
    logic [3:0]  acc_ptr, acc_wr_idx, sp;
    logic [6:0]  tk;
    logic [7:0]  pfx_wr_data;
    logic [15:0] instr_word, pc, mw_data, acc_wr_data, lc_wr_data, active_acc, st_data, lc1, a, k, t;
    logic [17:0] r;
    int          error_cnt, total_checks, cyc, seed;
    alb_exec DUT (.ref_clk, .rst, .instr_word, .instr_valid, .program_counter(pc), .ext_src_sel(),
        .ext_src_data(16'h0000), .ext_src_is_word(1'b0), .acc_ptr, .acc_wr_en, .acc_wr_idx, .acc_wr_data,
        .pfx_wr_en, .pfx_wr_data, .lc_wr_en, .lc_wr_idx, .lc_wr_data, .active_acc, .carry_flag, .sign_flag,
        .zero_flag, .equal_flag, .twos_complement_wrap_flag(ov_flag), .stack_top_pointer(sp),
        .stack_top_data(st_data), .loop_count_0(), .loop_count_1(lc1), .high_byte_prefix(),
        .instr_unsupported(unsup));
    alb_prog_mem PM (.ref_clk, .wr_en(mw_en), .wr_data(mw_data), .fetch_addr(pc), .fetch_word(instr_word));
    function automatic logic [17:0] add_exp(input logic [15:0] x, y, input logic ci);
        logic [16:0] s;
        s = x + y + 17'(ci);
        return {x[15] == y[15] && s[15] != x[15], s};
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ex(input logic [15:0] w);
        @(posedge ref_clk);
        {mw_en, mw_data} <= {1'b1, w};
        @(posedge ref_clk);
        {mw_en, instr_valid} <= 2'b01;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    task automatic ld(input int kind, input logic [3:0] idx, input logic [15:0] v);
        @(posedge ref_clk);
        {acc_wr_en, pfx_wr_en, lc_wr_en} <= {kind == 0, kind == 1, kind == 2};
        if (kind == 0) acc_ptr <= idx;
        {acc_wr_idx, lc_wr_idx, pfx_wr_data} <= {idx, idx[0], v[7:0]};
        {acc_wr_data, lc_wr_data} <= {v, v};
        @(posedge ref_clk);
        {acc_wr_en, pfx_wr_en, lc_wr_en} <= 3'b000;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (++cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        {rst, seed, c_m} = {1'b1, 32'sd13, 1'b0};
        {instr_valid, mw_en, acc_wr_en, pfx_wr_en, lc_wr_en, lc_wr_idx} = '0;
        {acc_ptr, acc_wr_idx, pfx_wr_data, mw_data, acc_wr_data, lc_wr_data} = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            a = 16'($random(seed));
            k = 16'($random(seed));
            ld(0, i[3:0], a);
            if (i[0]) ld(1, 4'h0, {8'h00, k[15:8]});
            else k[15:8] = 8'h00;
            r = add_exp(a, k, i[1] & c_m);
            ex({1'b0, i[1] ? OPF_ADD_WITH_CARRY_OP : OPF_ADD, k[7:0]});
            chk(active_acc, r[15:0]);
            chk(16'({carry_flag, ov_flag, sign_flag, zero_flag}), 16'({r[16], r[17], r[15], r[15:0] == 0}));
            c_m = r[16];
        end
        $display("add tests done");
        ld(0, 4'h2, 16'h2345);
        ld(1, 4'h0, 16'h000F);
        ex({1'b0, OPF_AND, 8'h33});
        chk(active_acc, 16'h2345 & 16'h0F33);
        chk(16'({carry_flag, sign_flag, zero_flag}), 16'({c_m, 2'b00}));
        for (int j = 0; j < 2; j++) begin
            if (j == 1) ld(1, 4'h0, 16'h0003);
            ex({1'b0, OPF_CMP, 8'h01});
            chk(16'(equal_flag), 16'(j));
            chk(active_acc, 16'h0301);
        end
        ex(INSTR_INVERT);
        chk(active_acc, 16'hFCFE);
        for (int j = 0; j < 3; j++) begin
            ex(INSTR_CPL_C);
            c_m = !c_m;
            chk(16'(carry_flag), 16'(c_m));
        end
        if (!c_m) ex(INSTR_CPL_C);
        c_m = 1'b1;
        for (int b = 1; b >= 0; b--) begin
            ex({HI_AND_BIT, 4'(b), LO_AND_BIT});
            c_m = c_m & active_acc[b];
            chk(16'(carry_flag), 16'(c_m));
        end
        $display("logic tests done");
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                ld(0, 4'h2, 16'hFFFF);
                ex(INSTR_INVERT);
                ex({1'b0, OPF_CMP, 8'h01});
                ex(INSTR_CPL_C);
                c_m = 1'b1;
            end
            tk = {!p[0], p[0], !p[0], !p[0], p[0], !c_m, c_m};
            for (int j = 0; j < 7; j++) begin
                t = pc;
                ex({1'b0, JOPS[j], 8'h03});
                chk(pc, t + (tk[j] ? 16'h0003 : 16'h0001));
            end
        end
        $display("jump tests done");
        t = pc;
        ex({1'b0, OPF_CALL, 8'hFE});
        chk(pc, t - 16'h0002);
        chk(st_data, t + 16'h0001);
        ld(1, 4'h0, 16'h0001);
        ex({1'b0, OPF_CALL, 8'h20});
        chk(pc, 16'h0120);
        ld(0, 4'h3, 16'h0300);
        ex({1'b1, OPF_CALL, 8'h39});
        chk(pc, 16'h0300);
        chk(16'(sp), 16'h0003);
        t = pc;
        ex({1'b0, OPF_JUMP, 8'h80});
        chk(pc, t - 16'h0080);
        ld(1, 4'h0, 16'h0004);
        ex({1'b0, OPF_JUMP, 8'h00});
        chk(pc, 16'h0400);
        ex({1'b1, OPF_JUMP, 8'h39});
        chk(pc, 16'h0300);
        ex(16'hDA3A);
        chk(16'(unsup), 16'h0001);
        ld(2, 4'h1, 16'h0002);
        for (int j = 0; j < 2; j++) begin
            t = pc;
            ex({1'b0, OPF_DECREMENT_BRANCH_NONZERO_HI, 1'b1, OPF_DECREMENT_BRANCH_NONZERO_LO, 8'h04});
            chk(lc1, 16'(1 - j));
            chk(pc, t + (j == 0 ? 16'h0004 : 16'h0001));
        end
        $display("branch tests done");
        print_verdict();
    end
endmodule
bind alb_exec alb_exec_asserts #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.ref_clk, .rst, .instr_word, .instr_valid,
    .program_counter, .acc_wr_en, .pfx_wr_en, .lc_wr_en, .active_acc, .carry_flag, .sign_flag, .zero_flag,
    .stack_top_pointer, .stack_top_data, .loop_count_1);
`default_nettype wire
